// *** hdl/bt_consts.svh ***
// Address map, field positions and reset values for the bus transfer logic
`ifndef BT_CONSTS_SVH
`define BT_CONSTS_SVH
`define BT_AW        12
`define BT_OFF_CTRL  12'h000
`define BT_OFF_DELAY 12'h004
`define BT_OFF_STAT  12'h008
`define BT_OFF_ISTS  12'h00c
`define BT_OFF_IMSK  12'h010
`define BT_CF_ROLE_LO 0
`define BT_CF_ROLE_HI 1
`define BT_CF_RDYEN   2
`define BT_CF_AUX3    3
`define BT_CTRL_RST   4'h0
`define BT_DELAY_W    16
`define BT_DELAY_RST  16'h0100
`define BT_NEV        3
`define BT_EV_INIT    0
`define BT_EV_RDYLOST 1
`define BT_EV_CLOSE   2
`define BT_NIN        21
`endif

// *** hdl/bt_pkg.sv ***
// Types shared by the bus transfer logic
package bt_pkg;
    typedef enum logic [1:0] {BT_ROLE_OFF, BT_ROLE_INC1, BT_ROLE_INC2, BT_ROLE_TIE} bt_role_t;
    typedef enum logic [2:0] {BT_R_CTRL, BT_R_DELAY, BT_R_STAT, BT_R_ISTS, BT_R_IMSK,
                              BT_R_NONE} bt_reg_t;
endpackage

// *** hdl/bt_transfer.sv ***
// Bus transfer supervision: readiness, initiation, blocking and tie close
`timescale 1ns/1ns
`include "bt_consts.svh"
module bt_transfer
    import bt_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [`BT_AW-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                own_breaker_closed_contact,
    input  wire logic                own_breaker_open_contact,
    input  wire logic                own_connected,
    input  wire logic                a_closed,
    input  wire logic                a_connected,
    input  wire logic                b_closed,
    input  wire logic                b_connected,
    input  wire logic                sel_to_trip_here,
    input  wire logic                block_transfer,
    input  wire logic                transformer_lockout,
    input  wire logic                source_trip,
    input  wire logic                uv_other_source,
    input  wire logic                inst_phase_overcurrent,
    input  wire logic                inst_neutral_overcurrent,
    input  wire logic                uv_definite,
    input  wire logic                uv_inverse,
    input  wire logic                close_from_incomer,
    input  wire logic                residual_above_limit,
    input  wire logic                in_sync,
    input  wire logic                live_line_dead_bus_permit,
    input  wire logic                dead_line_or_dead_bus_permit,
    output logic                     transfer_ready,
    output logic                     aux3,
    output logic                     aux4_trip_own,
    output logic                     aux5_close_req,
    output logic                     aux6_uv_block_out,
    output logic                     aux7_sel_trip_start,
    output logic                     tie_close,
    output logic                     sync_permit,
    output logic                     irq
);

// ============================================================
// Register decode
function automatic bt_reg_t dec(input logic [`BT_AW-1:0] a);
    if (a == `BT_OFF_CTRL) begin
        dec = BT_R_CTRL;
    end else if (a == `BT_OFF_DELAY) begin
        dec = BT_R_DELAY;
    end else if (a == `BT_OFF_STAT) begin
        dec = BT_R_STAT;
    end else if (a == `BT_OFF_ISTS) begin
        dec = BT_R_ISTS;
    end else if (a == `BT_OFF_IMSK) begin
        dec = BT_R_IMSK;
    end else begin
        dec = BT_R_NONE;
    end
endfunction

logic [3:0]             ctrl_r;
logic [`BT_DELAY_W-1:0] delay_r;
logic [`BT_NEV-1:0]     ists_r;
logic [`BT_NEV-1:0]     imsk_r;
logic [`BT_NEV-1:0]     ev;
logic [`BT_NEV-1:0]     ists_nxt;
logic [`BT_NIN-1:0]     in_r;
logic [`BT_DELAY_W-1:0] hold_cnt_r;
logic                   uv_hold_r;
logic                   trip_r;
logic                   latch_r;
logic                   ready_r;
logic [7:0]             stat;
bt_role_t               role;
bt_reg_t                sel_reg;
logic                   wr_acc;
logic                   setup;

assign setup   = psel & ~penable;
assign wr_acc  = psel & penable & pwrite;
assign sel_reg = dec(paddr);
assign pready  = 1'b1;
assign pslverr = psel & penable & (sel_reg == BT_R_NONE);
assign role    = bt_role_t'(ctrl_r[`BT_CF_ROLE_HI:`BT_CF_ROLE_LO]);

// ============================================================
// Input sampling
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        in_r <= '0;
    end else begin
        in_r <= {own_breaker_closed_contact, own_breaker_open_contact, own_connected,
                 a_closed, a_connected, b_closed, b_connected, sel_to_trip_here,
                 block_transfer, transformer_lockout, source_trip, uv_other_source,
                 inst_phase_overcurrent, inst_neutral_overcurrent, uv_definite, uv_inverse,
                 close_from_incomer, residual_above_limit, in_sync,
                 live_line_dead_bus_permit, dead_line_or_dead_bus_permit};
    end
end

logic                   s_cl;
logic                   s_op;
logic                   s_cn;
logic                   s_acl;
logic                   s_acn;
logic                   s_bcl;
logic                   s_bcn;
logic                   s_sel;
logic                   s_blk;
logic                   s_lo;
logic                   s_st;
logic                   s_uvo;
logic                   s_ocp;
logic                   s_ocn;
logic                   s_uvd;
logic                   s_uvi;
logic                   s_cfi;
logic                   s_res;
logic                   s_syn;
logic                   s_lldb;
logic                   s_dldb;
assign {s_cl, s_op, s_cn, s_acl, s_acn, s_bcl, s_bcn, s_sel, s_blk, s_lo, s_st,
        s_uvo, s_ocp, s_ocn, s_uvd, s_uvi, s_cfi, s_res, s_syn, s_lldb, s_dldb} = in_r;

// ============================================================
// Scheme logic
logic                   is_inc;
logic                   is_tie;
logic                   oc;
logic                   blocked;
logic                   ready_c;
logic                   init_c;
logic                   sel_c;
logic                   close_c;
assign is_inc = (role == BT_ROLE_INC1) | (role == BT_ROLE_INC2);
assign is_tie = (role == BT_ROLE_TIE);
assign oc     = s_ocp | s_ocn;
// On an incomer: a = other incomer, b = tie. On the tie: a = incomer 1, b = incomer 2.
assign ready_c = is_inc ? (~s_blk & ~s_bcl & s_cn & s_cl & s_acn & s_acl
                           & ~s_lo & ~s_st & ~s_uvd & ~s_uvo)
                        : (is_tie & ~s_blk & s_cn & ~s_cl & s_acl & s_bcl);
// Blocking covers connection, other-source state, fault and dip hold
assign blocked = s_blk | ~s_cn | ~s_acn | ~s_bcn | ~s_acl | oc | s_uvo | uv_hold_r;
assign init_c  = is_inc & (s_uvi | s_lo | s_st) & ~blocked & ~trip_r;
assign sel_c   = is_tie ? (s_acl & s_bcl & s_cn & s_cl & s_sel & ~s_blk)
                        : (is_inc & s_cn & s_acl & s_bcn & s_bcl & s_sel & ~s_blk);
// Residual check and line/bus permit only; the sync element has no say during a transfer
assign close_c = is_tie & latch_r & ~s_res & (s_dldb | s_lldb);

// Dip under fault holds the block until voltage stays good for the delay
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        uv_hold_r  <= 1'b0;
        hold_cnt_r <= '0;
    end else if (s_uvd & oc) begin
        uv_hold_r  <= 1'b1;
        hold_cnt_r <= '0;
    end else if (uv_hold_r) begin
        if (s_uvd) begin
            hold_cnt_r <= '0;
        end else if (hold_cnt_r >= delay_r) begin
            uv_hold_r  <= 1'b0;
        end else begin
            hold_cnt_r <= hold_cnt_r + 1'b1;
        end
    end
end

// Trip held until the own breaker reports open
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        trip_r <= 1'b0;
    end else if (init_c) begin
        trip_r <= 1'b1;
    end else if (s_op | ~is_inc) begin
        trip_r <= 1'b0;
    end
end

// Close request captured on the tie unit
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        latch_r <= 1'b0;
    end else if (~is_tie | s_cl | s_blk) begin
        latch_r <= 1'b0;
    end else if (s_cfi) begin
        latch_r <= 1'b1;
    end
end

// ============================================================
// Registered outputs
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ready_r             <= 1'b0;
        aux3                <= 1'b0;
        aux4_trip_own       <= 1'b0;
        aux5_close_req      <= 1'b0;
        aux6_uv_block_out   <= 1'b0;
        aux7_sel_trip_start <= 1'b0;
        tie_close           <= 1'b0;
        sync_permit         <= 1'b0;
    end else begin
        ready_r             <= ready_c;
        aux3                <= ctrl_r[`BT_CF_RDYEN] ? ready_c : ctrl_r[`BT_CF_AUX3];
        // Trip pair held by trip_r until the own breaker opens; the rest fall as soon as their condition goes
        aux4_trip_own       <= init_c | (trip_r & ~s_op & is_inc);
        aux5_close_req      <= init_c | (trip_r & ~s_op & is_inc);
        aux6_uv_block_out   <= is_inc & s_uvd;
        aux7_sel_trip_start <= sel_c;
        tie_close           <= close_c;
        sync_permit         <= s_syn & ~latch_r;
    end
end
assign transfer_ready = ready_r;

// ============================================================
// Interrupts
assign ev[`BT_EV_INIT]    = init_c;
assign ev[`BT_EV_RDYLOST] = ready_r & ~ready_c;
assign ev[`BT_EV_CLOSE]   = close_c & ~tie_close;

genvar gi;
generate
    for (gi = 0; gi < `BT_NEV; gi++) begin : g_ists
        // Set wins over a same-cycle write-one-to-clear
        assign ists_nxt[gi] = ev[gi] |
                              (ists_r[gi] & ~(wr_acc & (sel_reg == BT_R_ISTS) & pwdata[gi]));
    end
endgenerate

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ists_r <= '0;
    end else begin
        ists_r <= ists_nxt;
    end
end

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq <= 1'b0;
    end else begin
        irq <= |(ists_r & imsk_r);
    end
end

// ============================================================
// Register writes
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_r  <= `BT_CTRL_RST;
        delay_r <= `BT_DELAY_RST;
        imsk_r  <= '0;
    end else if (wr_acc) begin
        if (sel_reg == BT_R_CTRL) begin
            ctrl_r <= pwdata[3:0];
        end else if (sel_reg == BT_R_DELAY) begin
            delay_r <= pwdata[`BT_DELAY_W-1:0];
        end else if (sel_reg == BT_R_IMSK) begin
            imsk_r <= pwdata[`BT_NEV-1:0];
        end
    end
end

// ============================================================
// Register reads, captured in the setup cycle
assign stat = {sync_permit, tie_close, uv_hold_r, latch_r, trip_r, aux3, ready_r, blocked};

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= '0;
    end else if (setup & ~pwrite) begin
        if (sel_reg == BT_R_CTRL) begin
            prdata <= {28'h0000000, ctrl_r};
        end else if (sel_reg == BT_R_DELAY) begin
            prdata <= {16'h0000, delay_r};
        end else if (sel_reg == BT_R_STAT) begin
            prdata <= {24'h000000, stat};
        end else if (sel_reg == BT_R_ISTS) begin
            prdata <= {29'h00000000, ists_r};
        end else if (sel_reg == BT_R_IMSK) begin
            prdata <= {29'h00000000, imsk_r};
        end else begin
            prdata <= '0;
        end
    end
end

endmodule

// *** verif/bt_brk_model.sv ***
// Breaker model: auxiliary contacts follow trip and close coils after a delay
`timescale 1ns/1ns
module bt_brk_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic trip,
    input  wire logic close_cmd,
    output logic      closed,
    output logic      opened
);
    logic [2:0] dly_r;
    // Slow mechanism so a trip that is not held gets noticed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_r <= 3'h0;
            closed <= 1'b1;
        end else if ((trip && closed) || (close_cmd && !closed)) begin
            dly_r <= dly_r + 3'h1;
            if (dly_r == 3'h7) begin
                closed <= !closed;
            end
        end else begin
            dly_r <= 3'h0;
        end
    end
    assign opened = !closed;
endmodule

// *** verif/bt_chk.sv ***
// Checker: timing relations of the bus transfer scheme outputs
`timescale 1ns/1ns
module bt_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic block_transfer,
    input wire logic a_closed,
    input wire logic b_closed,
    input wire logic sel_to_trip_here,
    input wire logic own_breaker_open_contact,
    input wire logic uv_inverse,
    input wire logic transformer_lockout,
    input wire logic source_trip,
    input wire logic inst_phase_overcurrent,
    input wire logic inst_neutral_overcurrent,
    input wire logic residual_above_limit,
    input wire logic transfer_ready,
    input wire logic aux4_trip_own,
    input wire logic aux5_close_req,
    input wire logic aux7_sel_trip_start,
    input wire logic tie_close,
    input wire logic sync_permit
);
    // ========================================
    // Outputs lag the sampled inputs by two edges
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    rdy_no_blk_a: assert property (transfer_ready |-> !$past(block_transfer, 2))
        else $error("ready while blocked");
    rdy_src_a: assert property (transfer_ready |-> $past(a_closed, 2))
        else $error("ready with incomer open");
    trip_pair_a: assert property ($rose(aux4_trip_own) |-> aux5_close_req)
        else $error("trip without close request");
    trip_hold_a: assert property ($fell(aux4_trip_own) |-> $past(own_breaker_open_contact, 2))
        else $error("trip dropped before breaker open");
    trip_cause_a: assert property ($rose(aux4_trip_own) |->
        $past(uv_inverse | transformer_lockout | source_trip, 2))
        else $error("trip without cause");
    trip_ocp_a: assert property ($rose(aux4_trip_own) |->
        !$past(inst_phase_overcurrent | inst_neutral_overcurrent, 2))
        else $error("trip during overcurrent");
    close_res_a: assert property (tie_close |-> !$past(residual_above_limit, 2))
        else $error("close with residual voltage");
    sync_off_a: assert property (tie_close |-> !sync_permit)
        else $error("sync permit during transfer");
    sel_trip_a: assert property (aux7_sel_trip_start |-> $past(a_closed & b_closed
        & sel_to_trip_here & !block_transfer, 2))
        else $error("select trip start unqualified");
    trip_c: cover property ($rose(aux4_trip_own));
    close_c: cover property ($rose(tie_close));
    ready_c: cover property ($rose(transfer_ready));
endmodule
bind bt_transfer bt_chk bt_chk_i (.*);

// *** verif/bt_transfer_tb_top.sv ***
// Testbench: registers, interrupts and transfer scheme sequences
`timescale 1ns/1ns
`include "bt_consts.svh"
module bt_transfer_tb_top;
    localparam logic [18:0] INC = 19'h74006;
    localparam logic [18:0] TIE = 19'h7c007;
    localparam int BLK = 12, UVD = 6, UVI = 5, CFI = 4, RES = 3, SEL = 13, OCP = 8;
    logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
    logic        mopen = '0, mclose = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [18:0] iv = '0;
    logic [32:0] qe[$], qm[$], e, m;
    int          error_cnt = 0, comparisons = 0, cyc = 0, d;
    int          nrdy[5] = '{12, 9, 6, 15, 17};
    int          ninit[5] = '{8, 7, 9, 12, 17};
    int          cause[3] = '{5, 11, 10};
    wire [31:0]  prdata;
    wire pready, pslverr, transfer_ready, aux3, aux4_trip_own, aux5_close_req, irq;
    wire aux6_uv_block_out, aux7_sel_trip_start, tie_close, sync_permit;
    wire own_breaker_closed_contact, own_breaker_open_contact, own_connected, a_closed;
    wire a_connected, b_closed, b_connected, sel_to_trip_here, block_transfer;
    wire transformer_lockout, source_trip, uv_other_source, inst_phase_overcurrent;
    wire inst_neutral_overcurrent, uv_definite, uv_inverse, close_from_incomer;
    wire residual_above_limit, in_sync, live_line_dead_bus_permit, dead_line_or_dead_bus_permit;
    assign {own_connected, a_closed, a_connected, b_closed, b_connected, sel_to_trip_here,
            block_transfer, transformer_lockout, source_trip, uv_other_source,
            inst_phase_overcurrent, inst_neutral_overcurrent, uv_definite, uv_inverse,
            close_from_incomer, residual_above_limit, in_sync, live_line_dead_bus_permit,
            dead_line_or_dead_bus_permit} = iv;
    bt_transfer bt_transfer_i (.*);
    bt_brk_model bt_brk_model_i (.pclk(pclk), .presetn(presetn), .trip(aux4_trip_own | mopen),
        .close_cmd(tie_close | mclose), .closed(own_breaker_closed_contact),
        .opened(own_breaker_open_contact));
    // ========================================
    // Clock, timeout and read monitor
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            give_verdict();
        end
    end
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            e = qe.pop_front();
            m = qm.pop_front();
            cmp("prdata", e & m, {pslverr, prdata} & m);
        end
    end
    task give_verdict;
        if (error_cnt == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task cmp(input string n, input logic [32:0] x, input logic [32:0] s);
        comparisons++;
        if (s !== x) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", n, x, s);
        end
    endtask
    task pin(input string n, input logic s, input logic x);
        cmp(n, {32'h0, x}, {32'h0, s});
    endtask
    task w(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Zero wait slave, yet the access phase still waits on pready
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] dt);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [32:0] x, input logic [32:0] mk);
        qe.push_back(x);
        qm.push_back(mk);
        apb(1'b0, a, 32'h0);
    endtask
    task brk(input logic op);
        mopen <= op;
        mclose <= !op;
        w(12);
        mopen <= 1'b0;
        mclose <= 1'b0;
    endtask
    // ========================================
    // Main sequence
    initial begin
        void'($urandom(32'h943bd609));
        d = 8 + $urandom_range(3);
        w(16);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd(12'(4 * i), i == 1 ? 33'h100 : i == 2 ? 33'h1 :
               i == 5 ? 33'h100000000 : 33'h0, '1);
        pin("outs", |{aux3, aux4_trip_own, aux5_close_req, aux6_uv_block_out,
            aux7_sel_trip_start, tie_close, irq}, 1'b0);
        pin("pready", pready, 1'b1);
        apb(1'b1, `BT_OFF_CTRL, 32'h5);
        apb(1'b1, `BT_OFF_IMSK, 32'h7);
        iv <= INC;
        w(6);
        pin("ready", transfer_ready, 1'b1);
        pin("aux3", aux3, 1'b1);
        rd(`BT_OFF_STAT, 33'h2, 33'h3);
        foreach (nrdy[k]) begin
            iv <= INC ^ (19'h1 << nrdy[k]);
            w(6);
            pin("ready", transfer_ready, 1'b0);
            pin("aux6", aux6_uv_block_out, nrdy[k] == UVD);
            iv <= INC;
            w(6);
        end
        rd(`BT_OFF_ISTS, 33'h2, 33'h2);
        pin("irq", irq, 1'b1);
        apb(1'b1, `BT_OFF_ISTS, 32'h2);
        apb(1'b1, `BT_OFF_CTRL, 32'h1);
        apb(1'b1, `BT_OFF_IMSK, 32'h0);
        w(4);
        pin("irq", irq, 1'b0);
        pin("aux3", aux3, 1'b0);
        foreach (cause[k]) begin
            iv <= INC | (19'h1 << cause[k]);
            w(5);
            cmp("trip", 33'h3, {31'h0, aux4_trip_own, aux5_close_req});
            iv <= INC;
            w(4);
            pin("trip", aux4_trip_own, 1'b1);
            w(12);
            pin("trip", aux4_trip_own, 1'b0);
            brk(1'b0);
        end
        foreach (ninit[k]) begin
            iv <= (INC | (19'h1 << UVI)) ^ (19'h1 << ninit[k]);
            w(8);
            pin("trip", aux4_trip_own, 1'b0);
        end
        pin("irq", irq, 1'b0);
        rd(`BT_OFF_ISTS, 33'h1, 33'h1);
        apb(1'b1, `BT_OFF_IMSK, 32'h7);
        w(3);
        pin("irq", irq, 1'b1);
        apb(1'b1, `BT_OFF_ISTS, 32'h7);
        apb(1'b1, `BT_OFF_DELAY, d);
        iv <= INC | (19'h1 << OCP) | (19'h1 << UVD);
        w(4);
        iv <= INC | (19'h1 << UVI);
        w(5);
        pin("trip", aux4_trip_own, 1'b0);
        rd(`BT_OFF_STAT, 33'h20, 33'h20);
        w(d + 2);
        pin("trip", aux4_trip_own, 1'b1);
        pin("irq", irq, 1'b1);
        iv <= INC;
        w(14);
        brk(1'b0);
        apb(1'b1, `BT_OFF_CTRL, 32'h7);
        brk(1'b1);
        iv <= TIE;
        w(6);
        pin("ready", transfer_ready, 1'b1);
        iv <= TIE | (19'h1 << CFI) | (19'h1 << RES);
        w(1);
        iv <= TIE | (19'h1 << RES);
        w(5);
        rd(`BT_OFF_STAT, 33'h10, 33'hd0);
        iv <= TIE;
        w(5);
        pin("close", tie_close, 1'b1);
        w(16);
        rd(`BT_OFF_STAT, 33'h0, 33'h50);
        iv <= TIE | (19'h1 << SEL);
        w(6);
        pin("seltrip", aux7_sel_trip_start, 1'b1);
        iv <= TIE | (19'h1 << SEL) | (19'h1 << BLK);
        w(6);
        pin("seltrip", aux7_sel_trip_start, 1'b0);
        brk(1'b1);
        iv <= TIE | (19'h1 << CFI) | (19'h1 << RES);
        w(1);
        iv <= TIE | (19'h1 << RES) | (19'h1 << BLK);
        w(6);
        rd(`BT_OFF_STAT, 33'h0, 33'h10);
        rd(`BT_OFF_ISTS, 33'h4, 33'h4);
        give_verdict();
    end
endmodule
